// File: rtl/eead_master.sv
/*
 Autodetect master: bit and byte engine on the two-wire link plus a
 sequencer that finds the EEPROM addressing scheme and then its size.
 Assumes one EEPROM on the link, no clock stretching and no write-cycle
 delay in the slave (write completion polling is not done).
*/
// Summary of operation
// RULE1 - Master drives clock, start and stop
// RULE2 - Control byte: 1010, chip selects, read/write
// RULE3 - Slave drives reads and acknowledges writes
// RULE4 - One-byte mode: one address, block selects
// RULE5 - Two-byte mode: two address bytes follow
// RULE6 - One flag steers read and write addressing
// RULE7 - Detect: two-byte mode, write 01 at 0000
// RULE8 - One-byte part stores 00, 01 there
// RULE9 - Then one-byte mode, read location 0000
// RULE10 - Two-byte part returns location 0000 anyway
// RULE11 - Read 1 two-byte, 0 one-byte
// RULE12 - Locations 0000 and 0001 get overwritten
// RULE13 - Addresses wrap modulo capacity
// RULE14 - Size test: compare, bump, recompare, restore
// RULE15 - Candidates 128..2048 or 4096..32768, doubling
// RULE16 - Missing acknowledge aborts with fault
`timescale 1ns/100ps
`default_nettype none
`include "eead_cfg.svh"

module eead_master import eead_pkg::*; (
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        detectStart,
	input  wire logic [2:0]  chipSel,
	output var  logic        busy,
	output var  logic        done,
	output var  logic        fault,
	output var  logic        twoByteAddr,
	output var  logic [15:0] memSize,
	eead_link_if.master      link
);

	localparam logic [8:0] QTR_LAST = 9'(`EEAD_QTR_CYC - 1);

	// Byte engine state
	eead_op_t   engOp_q, engOp_d;
	logic       engBusy_q, engBusy_d;
	logic [8:0] qCnt_q, qCnt_d;
	logic [1:0] phase_q, phase_d;
	logic [3:0] bitCnt_q, bitCnt_d;
	logic [7:0] tx_q, tx_d;
	logic [7:0] rx_q, rx_d;
	logic       nack_q, nack_d;
	logic       engDone_q, engDone_d;
	logic       scl_q, scl_d;
	logic       sdaRel_q, sdaRel_d;

	// Sequencer state
	eead_seq_t   st_q, st_d;
	logic [2:0]  step_q, step_d;
	logic        stepBusy_q, stepBusy_d;
	logic        abort_q, abort_d;
	logic        smart_q, smart_d;
	logic        hit_q, hit_d;
	logic [15:0] n_q, n_d;
	logic [7:0]  temp_q, temp_d;
	logic        done_q, done_d;
	logic        fault_q, fault_d;
	logic [15:0] size_q, size_d;

	// Requests from sequencer to engine
	logic        engReq;
	eead_op_t    reqOp;
	logic [7:0]  reqByte;
	logic        isRd;
	logic [15:0] tAddr;
	logic [7:0]  tData;
	logic [2:0]  csBits;
	logic [2:0]  lastStep;
	logic        sclHigh;

	assign sclHigh = phase_q[0] ^ phase_q[1];

	always_comb begin
		engOp_d   = engOp_q;
		engBusy_d = engBusy_q;
		qCnt_d    = qCnt_q;
		phase_d   = phase_q;
		bitCnt_d  = bitCnt_q;
		tx_d      = tx_q;
		rx_d      = rx_q;
		nack_d    = nack_q;
		engDone_d = 1'b0;
		scl_d     = scl_q;
		sdaRel_d  = sdaRel_q;
		if (!engBusy_q) begin
			if (engReq) begin
				engBusy_d = 1'b1;
				engOp_d   = reqOp;
				tx_d      = reqByte;
				qCnt_d    = 9'h000;
				phase_d   = 2'h0;
				bitCnt_d  = 4'h0;
				nack_d    = 1'b0;
			end
		end else begin
			// Only the master shapes the clock and the start/stop edges, see RULE1
			case (engOp_q)
				OP_START: begin
					scl_d    = sclHigh;
					sdaRel_d = ~phase_q[1];
				end
				OP_STOP: begin
					scl_d    = (phase_q != 2'h0);
					sdaRel_d = phase_q[1];
				end
				OP_WRITE: begin
					scl_d    = sclHigh;
					sdaRel_d = (bitCnt_q == 4'h8) | tx_q[7];
				end
				default: begin
					// Read: released throughout, ack slot left high as not-ack
					scl_d    = sclHigh;
					sdaRel_d = 1'b1;
				end
			endcase
			if (qCnt_q == QTR_LAST) begin
				qCnt_d  = 9'h000;
				phase_d = phase_q + 2'h1;
				if (phase_q == 2'h1 && engOp_q == OP_WRITE && bitCnt_q == 4'h8) begin
					nack_d = link.sda; // see RULE3
				end
				if (phase_q == 2'h1 && engOp_q == OP_READ && bitCnt_q != 4'h8) begin
					rx_d = {rx_q[6:0], link.sda}; // see RULE3
				end
				if (phase_q == 2'h3) begin
					if (engOp_q == OP_START || engOp_q == OP_STOP || bitCnt_q == 4'h8) begin
						engBusy_d = 1'b0;
						engDone_d = 1'b1;
					end else begin
						bitCnt_d = bitCnt_q + 4'h1;
						tx_d     = {tx_q[6:0], 1'b0};
					end
				end
			end else begin
				qCnt_d = qCnt_q + 9'h001;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			engOp_q   <= OP_STOP;
			engBusy_q <= 1'b0;
			qCnt_q    <= 9'h000;
			phase_q   <= 2'h0;
			bitCnt_q  <= 4'h0;
			tx_q      <= 8'h00;
			rx_q      <= 8'h00;
			nack_q    <= 1'b0;
			engDone_q <= 1'b0;
			scl_q     <= 1'b1;
			sdaRel_q  <= 1'b1;
		end else begin
			engOp_q   <= engOp_d;
			engBusy_q <= engBusy_d;
			qCnt_q    <= qCnt_d;
			phase_q   <= phase_d;
			bitCnt_q  <= bitCnt_d;
			tx_q      <= tx_d;
			rx_q      <= rx_d;
			nack_q    <= nack_d;
			engDone_q <= engDone_d;
			scl_q     <= scl_d;
			sdaRel_q  <= sdaRel_d;
		end
	end

	// Transaction issued by each sequencer state
	always_comb begin
		isRd  = 1'b1;
		tAddr = `EEAD_LOC_ZERO;
		tData = temp_q;
		case (st_q)
			S_DETWR: begin
				isRd  = 1'b0;
				tData = `EEAD_DET_DATA; // see RULE7
			end
			S_RDN, S_RDN2: tAddr = n_q; // see RULE13
			S_WRP1: begin
				isRd  = 1'b0;
				tData = temp_q + 8'h01; // see RULE14
			end
			S_RESTORE: isRd = 1'b0;
			default: isRd = 1'b1;
		endcase
	end

	// Flag picks block bits or chip selects for every command, see RULE6
	assign csBits   = smart_q ? chipSel : tAddr[10:8]; // see RULE4
	assign lastStep = isRd ? `EEAD_STEP_RLAST : `EEAD_STEP_WLAST;

	always_comb begin
		reqOp   = OP_STOP;
		reqByte = {`EEAD_MEM_ID, csBits, `EEAD_RW_WRITE}; // see RULE2
		case (step_q)
			3'd0: reqOp = OP_START;
			`EEAD_STEP_CTRLW: reqOp = OP_WRITE;
			`EEAD_STEP_ADDRH: begin
				reqOp   = OP_WRITE;
				reqByte = tAddr[15:8]; // see RULE5
			end
			`EEAD_STEP_ADDRL: begin
				reqOp   = OP_WRITE;
				reqByte = tAddr[7:0];
			end
			3'd4: begin
				reqOp   = isRd ? OP_START : OP_WRITE;
				reqByte = tData;
			end
			3'd5: begin
				reqOp   = isRd ? OP_WRITE : OP_STOP;
				reqByte = {`EEAD_MEM_ID, csBits, `EEAD_RW_READ};
			end
			3'd6: reqOp = OP_READ;
			default: reqOp = OP_STOP;
		endcase
	end

	always_comb begin
		st_d       = st_q;
		step_d     = step_q;
		stepBusy_d = stepBusy_q;
		abort_d    = abort_q;
		smart_d    = smart_q;
		hit_d      = hit_q;
		n_d        = n_q;
		temp_d     = temp_q;
		done_d     = 1'b0;
		fault_d    = fault_q;
		size_d     = size_q;
		engReq     = 1'b0;
		if (st_q == S_IDLE) begin
			if (detectStart) begin
				st_d    = S_DETWR;
				smart_d = 1'b1; // see RULE7
				fault_d = 1'b0;
				abort_d = 1'b0;
				step_d  = 3'd0;
			end
		end else if (!stepBusy_q) begin
			engReq     = 1'b1;
			stepBusy_d = 1'b1;
		end else if (engDone_q) begin
			stepBusy_d = 1'b0;
			if (abort_q) begin
				// Stop has closed the bus after a missing acknowledge
				st_d    = S_IDLE;
				fault_d = 1'b1;
				done_d  = 1'b1;
			end else if (reqOp == OP_WRITE && nack_q) begin
				abort_d = 1'b1; // see RULE16
				step_d  = lastStep;
			end else if (step_q != lastStep) begin
				step_d = step_q + 3'd1;
				if (step_q == `EEAD_STEP_CTRLW && !smart_q) begin
					step_d = `EEAD_STEP_ADDRL; // see RULE4
				end
			end else begin
				step_d = 3'd0;
				case (st_q)
					S_DETWR: begin
						// Old contents of 0000/0001 are lost here, see RULE12
						smart_d = 1'b0; // see RULE9
						st_d    = S_DETRD;
					end
					S_DETRD: begin
						// A two-byte part answers from 0000 as well, see RULE10
						if (rx_q == `EEAD_DET_DATA) begin
							smart_d = 1'b1; // see RULE11
							n_d     = `EEAD_TWO_FIRST; // see RULE15
							st_d    = S_RD0;
						end else if (rx_q == `EEAD_DET_STD) begin
							n_d  = `EEAD_STD_FIRST;
							st_d = S_RD0;
						end else begin
							st_d    = S_IDLE;
							fault_d = 1'b1;
							done_d  = 1'b1;
						end
					end
					S_RD0: begin
						temp_d = rx_q;
						st_d   = S_RDN;
					end
					S_RDN: begin
						if (rx_q == temp_q) begin
							st_d = S_WRP1; // see RULE14
						end else if (n_q == (smart_q ? `EEAD_TWO_LAST : `EEAD_STD_LAST)) begin
							st_d    = S_IDLE;
							fault_d = 1'b1;
							done_d  = 1'b1;
						end else begin
							n_d = {n_q[14:0], 1'b0}; // see RULE15
						end
					end
					S_WRP1: st_d = S_RDN2;
					S_RDN2: begin
						hit_d = (rx_q == temp_q + 8'h01); // see RULE14
						st_d  = S_RESTORE;
					end
					default: begin
						// Location 0 is restored even on a miss
						if (hit_q) begin
							st_d   = S_IDLE;
							size_d = n_q;
							done_d = 1'b1;
						end else if (n_q == (smart_q ? `EEAD_TWO_LAST : `EEAD_STD_LAST)) begin
							st_d    = S_IDLE;
							fault_d = 1'b1;
							done_d  = 1'b1;
						end else begin
							n_d  = {n_q[14:0], 1'b0};
							st_d = S_RDN;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st_q       <= S_IDLE;
			step_q     <= 3'd0;
			stepBusy_q <= 1'b0;
			abort_q    <= 1'b0;
			smart_q    <= 1'b0;
			hit_q      <= 1'b0;
			n_q        <= 16'h0000;
			temp_q     <= 8'h00;
			done_q     <= 1'b0;
			fault_q    <= 1'b0;
			size_q     <= 16'h0000;
			busy       <= 1'b0;
		end else begin
			st_q       <= st_d;
			step_q     <= step_d;
			stepBusy_q <= stepBusy_d;
			abort_q    <= abort_d;
			smart_q    <= smart_d;
			hit_q      <= hit_d;
			n_q        <= n_d;
			temp_q     <= temp_d;
			done_q     <= done_d;
			fault_q    <= fault_d;
			size_q     <= size_d;
			busy       <= (st_d != S_IDLE);
		end
	end

	assign done          = done_q;
	assign fault         = fault_q;
	assign twoByteAddr   = smart_q;
	assign memSize       = size_q;
	assign link.scl      = scl_q;
	assign link.mSdaOut  = sdaRel_q;
	assign link.mSdaOe_n = sdaRel_q;

endmodule

`default_nettype wire

// File: rtl/eead_cfg.svh
/*
 Constants of the EEPROM addressing and size autodetect pair: bus timing,
 control byte layout, detection values and candidate size limits.
 Assumes inclusion by the package or modules that need these figures.
*/
`ifndef EEAD_CFG_SVH
`define EEAD_CFG_SVH

// Timing
`define EEAD_CLK_NS      8
// Fast bit keeps a full run to a few thousand mclk; slave needs 2+ mclk a quarter
`define EEAD_BIT_NS      160
`define EEAD_QTR_NS      (`EEAD_BIT_NS / 4)
`define EEAD_QTR_CYC     ((`EEAD_QTR_NS + `EEAD_CLK_NS - 1) / `EEAD_CLK_NS)

// Control byte
`define EEAD_MEM_ID      4'ha
`define EEAD_RW_READ     1'b1
`define EEAD_RW_WRITE    1'b0

// Detection sequence
`define EEAD_LOC_ZERO    16'h0000
`define EEAD_DET_DATA    8'h01
`define EEAD_DET_STD     8'h00

// Candidate sizes in bytes
`define EEAD_STD_FIRST   16'h0080
`define EEAD_STD_LAST    16'h0800
`define EEAD_TWO_FIRST   16'h1000
`define EEAD_TWO_LAST    16'h8000

// Transaction step slots
`define EEAD_STEP_CTRLW  3'd1
`define EEAD_STEP_ADDRH  3'd2
`define EEAD_STEP_ADDRL  3'd3
`define EEAD_STEP_WLAST  3'd5
`define EEAD_STEP_RLAST  3'd7

`endif

// File: rtl/eead_pkg.sv
/*
 Types shared by the autodetect master and the EEPROM end: byte engine
 operations and the state encodings of both ends.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package eead_pkg;

	typedef enum logic [1:0] {
		OP_START = 2'h0,
		OP_WRITE = 2'h1,
		OP_READ  = 2'h3,
		OP_STOP  = 2'h2
	} eead_op_t;

	typedef enum logic [3:0] {
		S_IDLE    = 4'h0,
		S_DETWR   = 4'h1,
		S_DETRD   = 4'h3,
		S_RD0     = 4'h2,
		S_RDN     = 4'h6,
		S_WRP1    = 4'h7,
		S_RDN2    = 4'h5,
		S_RESTORE = 4'h4
	} eead_seq_t;

	typedef enum logic [2:0] {
		E_IDLE  = 3'h0,
		E_CTRL  = 3'h1,
		E_ADDRH = 3'h3,
		E_ADDRL = 3'h2,
		E_WRITE = 3'h6,
		E_READ  = 3'h7
	} eead_mem_t;

endpackage

// File: rtl/eead_link_if.sv
/*
 Two-wire link between the autodetect master and the EEPROM end.
 Assumes a pull-up on the data line: it resolves the wired-AND level from
 each end's output and active-low enable. The clock line is master-only.
*/
`timescale 1ns/100ps
`default_nettype none

interface eead_link_if;
	logic scl;
	logic mSdaOut;
	logic mSdaOe_n;
	logic sSdaOut;
	logic sSdaOe_n;
	wire  sda;

	assign sda = (mSdaOe_n | mSdaOut) & (sSdaOe_n | sSdaOut);

	modport master (output scl, output mSdaOut, output mSdaOe_n, input sda);
	modport slave  (input scl, output sSdaOut, output sSdaOe_n, input sda);
endinterface

`default_nettype wire

// File: rtl/eead_eeprom.sv
/*
 EEPROM end of the link: a byte-wide serial memory with one-byte or
 two-byte word addressing and address wrap at its capacity.
 Assumes the master alone drives the clock and that the clock is slow
 against mclk, so edges are seen by comparing samples.
*/
`timescale 1ns/100ps
`default_nettype none
`include "eead_cfg.svh"

module eead_eeprom import eead_pkg::*; #(
	parameter logic       TWO_BYTE  = 1'b0,
	parameter int         ADDR_BITS = 11,
	parameter logic [2:0] CHIP_SEL  = 3'h0
) (
	input  wire logic   mclk,
	input  wire logic   srst,
	output var  logic   busy,
	eead_link_if.slave  link
);

	localparam int DEPTH = 1 << ADDR_BITS;

	eead_mem_t   st_q, st_d;
	logic [3:0]  cnt_q, cnt_d;
	logic [7:0]  sh_q, sh_d;
	logic [7:0]  txSh_q, txSh_d;
	logic [15:0] ptr_q, ptr_d;
	logic        rel_q, rel_d;
	logic        mAck_q, mAck_d;
	logic        sclPrev_q;
	logic        sdaPrev_q;
	logic        memWe;
	logic [7:0]  mem_q [DEPTH];
	logic [7:0]  rdByte;
	logic        startSeen, stopSeen, sclRise, sclFall;

	assign startSeen = link.scl & sclPrev_q & sdaPrev_q & ~link.sda;
	assign stopSeen  = link.scl & sclPrev_q & ~sdaPrev_q & link.sda;
	assign sclRise   = link.scl & ~sclPrev_q;
	assign sclFall   = ~link.scl & sclPrev_q;
	// Upper address bits beyond capacity are ignored, see RULE13
	assign rdByte    = mem_q[ptr_q[ADDR_BITS-1:0]];

	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		sh_d   = sh_q;
		txSh_d = txSh_q;
		ptr_d  = ptr_q;
		rel_d  = rel_q;
		mAck_d = mAck_q;
		memWe  = 1'b0;
		if (startSeen) begin
			st_d  = E_CTRL;
			cnt_d = 4'h0;
			rel_d = 1'b1;
		end else if (stopSeen) begin
			st_d  = E_IDLE;
			rel_d = 1'b1;
		end else if (st_q != E_IDLE) begin
			if (sclRise) begin
				if (cnt_q[3]) begin
					mAck_d = ~link.sda;
				end else begin
					sh_d = {sh_q[6:0], link.sda};
				end
				cnt_d = cnt_q + 4'h1;
			end else if (sclFall) begin
				if (cnt_q == 4'h9) begin
					cnt_d = 4'h0;
					rel_d = 1'b1;
					if (st_q == E_READ) begin
						// Own ack after a read control byte also counts here
						if (mAck_q) begin
							rel_d  = rdByte[7]; // see RULE3
							txSh_d = {rdByte[6:0], 1'b0};
						end else begin
							st_d = E_IDLE;
						end
					end
				end else if (cnt_q == 4'h8) begin
					if (st_q == E_READ) begin
						rel_d = 1'b1;
						ptr_d = ptr_q + 16'h0001;
					end else begin
						rel_d = 1'b0; // see RULE3
						case (st_q)
							E_CTRL: begin
								if (sh_q[7:4] != `EEAD_MEM_ID ||
								    (TWO_BYTE && sh_q[3:1] != CHIP_SEL)) begin
									rel_d = 1'b1; // see RULE2
									st_d  = E_IDLE;
								end else begin
									if (!TWO_BYTE) begin
										ptr_d[10:8] = sh_q[3:1]; // see RULE4
									end
									if (sh_q[0]) begin
										st_d = E_READ;
									end else begin
										st_d = TWO_BYTE ? E_ADDRH : E_ADDRL; // see RULE5
									end
								end
							end
							E_ADDRH: begin
								// Partial addressing leaves the pointer at 0000, see RULE10
								ptr_d = {sh_q, 8'h00};
								st_d  = E_ADDRL;
							end
							E_ADDRL: begin
								ptr_d[7:0] = sh_q;
								st_d       = E_WRITE;
							end
							default: begin
								// Extra bytes are a sequential write, see RULE8
								memWe = 1'b1;
								ptr_d = ptr_q + 16'h0001;
							end
						endcase
					end
				end else if (st_q == E_READ && cnt_q != 4'h0) begin
					rel_d  = txSh_q[7];
					txSh_d = {txSh_q[6:0], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st_q      <= E_IDLE;
			cnt_q     <= 4'h0;
			sh_q      <= 8'h00;
			txSh_q    <= 8'h00;
			ptr_q     <= 16'h0000;
			rel_q     <= 1'b1;
			mAck_q    <= 1'b0;
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
			busy      <= 1'b0;
		end else begin
			st_q      <= st_d;
			cnt_q     <= cnt_d;
			sh_q      <= sh_d;
			txSh_q    <= txSh_d;
			ptr_q     <= ptr_d;
			rel_q     <= rel_d;
			mAck_q    <= mAck_d;
			sclPrev_q <= link.scl;
			sdaPrev_q <= link.sda;
			busy      <= (st_d != E_IDLE);
		end
	end

	// Cleared at reset so size probes never compare unknown data
	always_ff @(posedge mclk) begin
		if (srst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= 8'h00;
			end
		end else if (memWe) begin
			mem_q[ptr_q[ADDR_BITS-1:0]] <= sh_q;
		end
	end

	assign link.sSdaOut  = rel_q;
	assign link.sSdaOe_n = rel_q;

endmodule

`default_nettype wire

// File: sim/eead_link_sva.sv
/*
 Checker for the master end and the link of the autodetect pair.
 Assumes instantiation beside the link interface, fed with plain signals.
*/
`timescale 1ns/100ps
`default_nettype none
`include "eead_cfg.svh"

module eead_link_sva (
	input wire logic mclk,
	input wire logic srst,
	input wire logic detectStart,
	input wire logic busy,
	input wire logic done,
	input wire logic twoByteAddr,
	input wire logic scl,
	input wire logic sda,
	input wire logic mSdaOe_n,
	input wire logic sSdaOe_n
);
	// Longest gap to a start: stop tail, hand-over and two lead-in quarters
	localparam logic [7:0] START_WAIT = 8'(8 * `EEAD_QTR_CYC + 8);

	logic [7:0] waitCnt_q, waitCnt_d;
	logic       sclPrev_q, sdaPrev_q, frameOpen_q, firstByte_q;
	logic       frameOpen_d, firstByte_d, sclRise, startSeen, stopSeen;
	logic [3:0] bitCnt_q, bitCnt_d;
	logic [7:0] shReg_q, shReg_d;

	// Frame tracking from the wire alone, so a master slip cannot hide itself
	always_comb begin
		sclRise     = scl & ~sclPrev_q;
		startSeen   = scl & sclPrev_q & sdaPrev_q & ~sda;
		stopSeen    = scl & sclPrev_q & ~sdaPrev_q & sda;
		bitCnt_d    = bitCnt_q;
		shReg_d     = shReg_q;
		firstByte_d = firstByte_q;
		frameOpen_d = (frameOpen_q | startSeen) & ~stopSeen;
		waitCnt_d   = 8'h00;
		if (busy && !frameOpen_q && !startSeen) begin
			waitCnt_d = (waitCnt_q == 8'hff) ? waitCnt_q : waitCnt_q + 8'h01;
		end
		if (startSeen) begin
			bitCnt_d    = 4'h0;
			firstByte_d = 1'b1;
		end else if (sclRise) begin
			shReg_d  = {shReg_q[6:0], sda};
			bitCnt_d = (bitCnt_q == 4'h8) ? 4'h0 : bitCnt_q + 4'h1;
			if (bitCnt_q == 4'h8) begin
				firstByte_d = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			sclPrev_q   <= 1'b1;
			sdaPrev_q   <= 1'b1;
			frameOpen_q <= 1'b0;
			firstByte_q <= 1'b0;
			bitCnt_q    <= 4'h0;
			shReg_q     <= 8'h00;
			waitCnt_q   <= 8'h00;
		end else begin
			sclPrev_q   <= scl;
			sdaPrev_q   <= sda;
			frameOpen_q <= frameOpen_d;
			firstByte_q <= firstByte_d;
			bitCnt_q    <= bitCnt_d;
			shReg_q     <= shReg_d;
			waitCnt_q   <= waitCnt_d;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	sequence s_stop_idle;
		##1 (scl && sda) [*2];
	endsequence

	a_take_request: assert property ((detectStart && !busy && !done) |=> busy)
		else $error("request not taken");
	a_write_mode_first: assert property ($rose(busy) |-> twoByteAddr)
		else $error("run did not open in two-byte mode");
	a_start_opens: assert property ((busy && !frameOpen_q) |-> waitCnt_q < START_WAIT)
		else $error("no start condition after request");
	a_stop_then_idle: assert property (stopSeen |-> s_stop_idle)
		else $error("link not idle after stop");
	a_scl_idle_high: assert property (!busy |-> scl)
		else $error("clock line low while idle");
	a_done_frame_closed: assert property (done |-> !frameOpen_q && $past(busy))
		else $error("run ended inside an open frame");
	a_ctrl_mem_id: assert property ((sclRise && firstByte_q && bitCnt_q == 4'h3) |=> shReg_q[3:0] == 4'ha)
		else $error("control byte identifier wrong");
	a_ctrl_ack_slave: assert property ((sclRise && firstByte_q && bitCnt_q == 4'h8) |-> !sSdaOe_n)
		else $error("control byte not acknowledged");
	a_ack_master_free: assert property ((sclRise && firstByte_q && bitCnt_q == 4'h8) |-> mSdaOe_n)
		else $error("master holds data during acknowledge");
	a_flag_cleared_between: assert property ($fell(twoByteAddr) |-> busy && !frameOpen_q)
		else $error("mode flag changed inside a frame");
endmodule

`default_nettype wire

// File: sim/testbench.sv
/*
 Self-checking bench: a one-byte and a two-byte master/EEPROM pair, plus a
 master facing a far end that never acknowledges.
 Assumes the design files and the checker are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin n_fail++; \
	$display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end

module testbench;
	localparam int         BITS_A = 8;
	localparam int         BITS_B = 12;
	// Detection read goes out with block bits 000, so the two-byte part sits there
	localparam logic [2:0] SEL_B  = 3'h0;
	localparam int         LIMIT  = 30000;

	logic        mclk, srst;
	logic [2:0]  detectStart, busy, done, fault, twoByteAddr;
	logic [1:0]  eeBusy;
	logic [2:0]  chipSel [3];
	logic [15:0] memSize [3];
	int          n_fail, checked;

	eead_link_if link [3] ();

	// Silent far end on the third link: never drives, so no acknowledge
	assign link[2].sSdaOut  = 1'b1;
	assign link[2].sSdaOe_n = 1'b1;

	for (genvar k = 0; k < 3; k++) begin : g_master
		eead_master i_eead_master (.mclk(mclk), .srst(srst), .detectStart(detectStart[k]),
			.chipSel(chipSel[k]), .busy(busy[k]), .done(done[k]), .fault(fault[k]),
			.twoByteAddr(twoByteAddr[k]), .memSize(memSize[k]), .link(link[k]));
	end

	for (genvar k = 0; k < 2; k++) begin : g_eeprom
		eead_eeprom #(.TWO_BYTE(k == 1), .ADDR_BITS(k ? BITS_B : BITS_A), .CHIP_SEL(SEL_B))
			i_eead_eeprom (.mclk(mclk), .srst(srst), .busy(eeBusy[k]), .link(link[k]));
	end

	eead_link_sva i_eead_link_sva (.mclk(mclk), .srst(srst), .detectStart(detectStart[0]),
		.busy(busy[0]), .done(done[0]), .twoByteAddr(twoByteAddr[0]), .scl(link[0].scl),
		.sda(link[0].sda), .mSdaOe_n(link[0].mSdaOe_n), .sSdaOe_n(link[0].sSdaOe_n));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	function automatic logic [15:0] exp_size(input int bits);
		return 16'(1 << bits);
	endfunction

	task automatic complete_run;
		if (n_fail == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// One full detection; a stray request mid-run must be ignored
	task automatic run_det(input int k, input logic expTwo, input logic [15:0] expSize,
		input logic expFault);
		int n;
		int gap;
		gap = $urandom_range(40, 1);
		repeat (gap) @(posedge mclk);
		detectStart[k] <= 1'b1;
		@(posedge mclk);
		detectStart[k] <= 1'b0;
		for (n = 0; n < LIMIT; n++) begin
			@(negedge mclk);
			if (done[k] === 1'b1) begin
				break;
			end
			@(posedge mclk);
			detectStart[k] <= (n == gap * 4);
		end
		`CHK("done", 1'b1, done[k])
		`CHK("busy", 1'b0, busy[k])
		`CHK("fault", expFault, fault[k])
		if (!expFault) begin
			`CHK("twoByteAddr", expTwo, twoByteAddr[k])
			`CHK("memSize", expSize, memSize[k])
			`CHK("eeBusy", 1'b0, eeBusy[k])
		end else begin
			`CHK("memSize held", 16'h0000, memSize[k])
		end
		@(negedge mclk);
		`CHK("done pulse", 1'b0, done[k])
	endtask

	initial begin
		n_fail = 0;
		checked = 0;
		srst = 1'b1;
		detectStart = 3'h0;
		void'($urandom(86685));
		chipSel[0] = 3'($urandom);
		chipSel[1] = SEL_B;
		chipSel[2] = 3'($urandom);
		repeat (5) @(posedge mclk);
		srst <= 1'b0;
		fork
			run_det(0, 1'b0, exp_size(BITS_A), 1'b0);
			run_det(1, 1'b1, exp_size(BITS_B), 1'b0);
			begin
				run_det(2, 1'b0, 16'h0000, 1'b1);
				run_det(2, 1'b0, 16'h0000, 1'b1);
			end
		join
		complete_run;
	end

	// Slowest pair needs about eight thousand cycles; generous margin over it
	initial begin
		repeat (LIMIT + 20000) @(posedge mclk);
		n_fail++;
		complete_run;
	end
endmodule

`default_nettype wire
